/* hw/sar_clock_select.sv */
// master clock selection and divide-by-four conversion tick
// assumes master_clock_input is an asynchronous pin
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"

module sar_clock_select
    import sar_pkg::*;
#(
    parameter int IDLE_CYCLES = `SAR_IDLE_CYCLES,
    parameter int INT_DIV     = `SAR_INT_DIV
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // pin
    input  wire logic master_clock_input,
    // ticks
    output logic      master_tick,
    output logic      conv_tick,
    output logic      use_internal_osc
);

    localparam logic [11:0] IDLE_LAST = 12'(IDLE_CYCLES - 1);
    localparam logic [7:0]  OSC_LAST  = 8'(INT_DIV - 1);

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        prev;
        logic [11:0] idle_cnt;
        logic [7:0]  osc_cnt;
        logic [1:0]  quarter;
        logic        use_int;
        logic        mtick;
        logic        ctick;
        logic [2:0]  mt_since;
    } clk_state_t;

    clk_state_t s_reg;
    clk_state_t s_next;

    always_comb begin
        logic rise;
        logic tick;
        rise = 1'b0;
        tick = 1'b0;
        s_next = s_reg;
        s_next.sync1 = master_clock_input;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        rise = s_reg.sync2 & ~s_reg.prev;
        // pin held low long enough: fall back to the internal oscillator
        if (s_reg.sync2) begin
            s_next.idle_cnt = 12'h000;
            s_next.use_int = 1'b0;
        end else if (s_reg.idle_cnt == IDLE_LAST) begin
            s_next.use_int = 1'b1;
        end else begin
            s_next.idle_cnt = s_reg.idle_cnt + 12'h001;
        end
        s_next.osc_cnt = (s_reg.osc_cnt == OSC_LAST) ? 8'h00 : s_reg.osc_cnt + 8'h01;
        tick = s_reg.use_int ? (s_reg.osc_cnt == OSC_LAST) : rise;
        s_next.mtick = tick;
        s_next.ctick = tick && (s_reg.quarter == 2'h3);
        if (tick) begin
            s_next.quarter = s_reg.quarter + 2'h1;
        end
        if (s_reg.ctick) begin
            s_next.mt_since = 3'h0;
        end else if (s_reg.mtick) begin
            s_next.mt_since = s_reg.mt_since + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign master_tick      = s_reg.mtick;
    assign conv_tick        = s_reg.ctick;
    assign use_internal_osc = s_reg.use_int;

    a_div_four: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.ctick && $past(s_reg.ctick, 1) == 1'b0 && s_reg.mt_since != 3'h0)
        |-> (s_reg.mtick && s_reg.mt_since == 3'h3))
        else $error("conversion tick not every fourth master tick");

endmodule
`default_nettype wire

/* hw/sar_consts.svh */
// constants of the conversion sequencer: timing, reset values, trim layout
// assumes a 100 MHz system clock; included by bare name
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SAR_CLK_PERIOD_NS   10
`define SAR_MASTER_DIV      4
`define SAR_FINISH_TICKS    1
`define SAR_HOLD_MARGIN_NS  50
// slowest pin clock is 100 kHz, so no edge for 20 us means held low
`define SAR_IDLE_NS         20000
`define SAR_IDLE_CYCLES     (`SAR_IDLE_NS / `SAR_CLK_PERIOD_NS)
`define SAR_INT_DIV         25

// ****************************************************************
// calibration
// ****************************************************************
`define SAR_TRIM_W          6
`define SAR_TRIM_RESET      6'h20
`define SAR_CAL_STEPS       8

`endif

/* hw/sar_conversion_sequencer.sv */
// successive approximation sequencer with hold start, clamp and self calibration
// assumes comparator and range flags come from the analog front end, asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"

module sar_conversion_sequencer
    import sar_pkg::*;
#(
    parameter int RES         = 16,
    parameter int TRIM_W      = `SAR_TRIM_W,
    parameter int IDLE_CYCLES = `SAR_IDLE_CYCLES
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // pins from the host side
    input  wire logic                  master_clock_input,
    input  wire logic                  hold_n,
    input  wire logic                  bipolar,
    input  wire logic                  cal_start,
    // analog front end
    input  wire logic                  cmp_below,
    input  wire logic                  over_range,
    input  wire logic                  under_range,
    // capacitor array control
    output logic                       track,
    output logic                       msb_to_reference,
    output dac_mode_t                  dac_mode,
    output logic [RES-1:0]             dac_code,
    output logic [$clog2(RES)-1:0]     cal_bit,
    output logic [RES*TRIM_W-1:0]      trim_code,
    // result
    output logic [RES-1:0]             result,
    output logic                       result_done,
    output logic                       busy,
    output logic                       cal_busy,
    output logic                       use_internal_osc
);

    localparam int IDXW       = $clog2(RES);
    localparam int CONV_TICKS = `SAR_MASTER_DIV * RES + `SAR_FINISH_TICKS;
    localparam logic [RES-1:0]    MSB_ONLY = {1'b1, {(RES-1){1'b0}}};
    localparam logic [IDXW-1:0]   TOP_IDX  = IDXW'(RES - 1);
    localparam logic [TRIM_W-1:0] TRIM_MAX = '1;
    localparam logic [3:0]        CAL_LAST = 4'(`SAR_CAL_STEPS - 1);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [5:0]                   sync1;
        logic [5:0]                   sync2;
        logic                         hold_prev;
        logic                         cal_prev;
        seq_state_t                   state;
        logic [RES-1:0]               sar;
        logic [IDXW-1:0]              bit_idx;
        logic [RES-1:0]               result;
        logic                         done;
        logic                         clamp_hi;
        logic                         clamp_lo;
        logic [RES-1:0][TRIM_W-1:0]   trim;
        logic [IDXW-1:0]              cal_idx;
        logic [3:0]                   cal_step;
        logic [7:0]                   conv_cnt;
        logic [4:0]                   step_cnt;
        logic [2:0]                   wait_cnt;
    } seq_reg_t;

    seq_reg_t s_reg;
    seq_reg_t s_next;
    logic     master_tick;
    logic     conv_tick;
    logic     hold_fall;
    logic     cal_rise;

    sar_clock_select #(
        .IDLE_CYCLES (IDLE_CYCLES),
        .INT_DIV     (`SAR_INT_DIV)
    ) i_sar_clock_select (
        .clk                (clk),
        .reset_n            (reset_n),
        .master_clock_input (master_clock_input),
        .master_tick        (master_tick),
        .conv_tick          (conv_tick),
        .use_internal_osc   (use_internal_osc)
    );

    // hold is trusted to stay low past one master period, no glitch filter
    assign hold_fall = s_reg.hold_prev & ~s_reg.sync2[0];
    assign cal_rise  = ~s_reg.cal_prev & s_reg.sync2[5];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = {cal_start, bipolar, under_range, over_range, cmp_below, hold_n};
        s_next.sync2 = s_reg.sync1;
        s_next.hold_prev = s_reg.sync2[0];
        s_next.cal_prev = s_reg.sync2[5];
        s_next.done = 1'b0;
        // all durations are whole master periods
        if (master_tick && (s_reg.state == ST_CONVERT || s_reg.state == ST_FINISH)) begin
            s_next.conv_cnt = s_reg.conv_cnt + 8'h01;
        end
        if (master_tick && s_reg.state == ST_WAIT_SYNC) begin
            s_next.wait_cnt = s_reg.wait_cnt + 3'h1;
        end
        unique case (s_reg.state)
            ST_TRACK: begin
                if (cal_rise) begin
                    s_next.state = ST_CAL;
                    s_next.cal_idx = '0;
                    s_next.cal_step = 4'h0;
                end else if (hold_fall) begin
                    // sample frozen now, sequence waits for the divided clock
                    s_next.state = ST_WAIT_SYNC;
                    s_next.wait_cnt = 3'h0;
                end
            end
            ST_WAIT_SYNC: begin
                if (conv_tick) begin
                    s_next.state = ST_CONVERT;
                    s_next.sar = MSB_ONLY;
                    s_next.bit_idx = TOP_IDX;
                    s_next.conv_cnt = 8'h00;
                    s_next.step_cnt = 5'h00;
                    s_next.clamp_hi = 1'b0;
                    s_next.clamp_lo = 1'b0;
                end
            end
            ST_CONVERT: begin
                if (conv_tick) begin
                    // one decision per bit, msb first
                    if (s_reg.sync2[1]) begin
                        s_next.sar[s_reg.bit_idx] = 1'b0;
                    end
                    s_next.clamp_hi = s_reg.clamp_hi | s_reg.sync2[2];
                    s_next.clamp_lo = s_reg.clamp_lo | s_reg.sync2[3];
                    s_next.step_cnt = s_reg.step_cnt + 5'h01;
                    if (s_reg.bit_idx == '0) begin
                        s_next.state = ST_FINISH;
                    end else begin
                        s_next.bit_idx = s_reg.bit_idx - 1'b1;
                        s_next.sar[IDXW'(s_reg.bit_idx - 1'b1)] = 1'b1;
                    end
                end
            end
            ST_FINISH: begin
                if (master_tick) begin
                    // offset binary falls out of the array in bipolar mode
                    if (s_reg.clamp_hi) begin
                        s_next.result = '1;
                    end else if (s_reg.clamp_lo) begin
                        s_next.result = '0;
                    end else begin
                        s_next.result = s_reg.sar;
                    end
                    s_next.done = 1'b1;
                    // hold still low: a fresh conversion with no acquisition time
                    if (!s_reg.sync2[0]) begin
                        s_next.state = ST_WAIT_SYNC;
                        s_next.wait_cnt = 3'h0;
                    end else begin
                        s_next.state = ST_TRACK;
                    end
                end
            end
            ST_CAL: begin
                // hold is ignored while calibrating
                if (conv_tick) begin
                    // below means bit weight short of lower sum plus dummy lsb
                    if (s_reg.sync2[1] && s_reg.trim[s_reg.cal_idx] != TRIM_MAX) begin
                        s_next.trim[s_reg.cal_idx] = s_reg.trim[s_reg.cal_idx] + 1'b1;
                    end else if (!s_reg.sync2[1] && s_reg.trim[s_reg.cal_idx] != '0) begin
                        s_next.trim[s_reg.cal_idx] = s_reg.trim[s_reg.cal_idx] - 1'b1;
                    end
                    s_next.cal_step = s_reg.cal_step + 4'h1;
                    if (s_reg.cal_step == CAL_LAST) begin
                        s_next.cal_step = 4'h0;
                        if (s_reg.cal_idx == TOP_IDX) begin
                            s_next.state = ST_TRACK;
                        end else begin
                            s_next.cal_idx = s_reg.cal_idx + 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_next.state = ST_TRACK;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
            s_reg.sync1 <= 6'h01;
            s_reg.sync2 <= 6'h01;
            s_reg.hold_prev <= 1'b1;
            s_reg.state <= ST_TRACK;
            s_reg.trim <= {RES{`SAR_TRIM_RESET}};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign track            = (s_reg.state == ST_TRACK);
    assign msb_to_reference = s_reg.sync2[4] && (s_reg.state == ST_TRACK);
    assign dac_mode         = (s_reg.state == ST_TRACK) ? DAC_TRACK :
                              (s_reg.state == ST_CAL) ? DAC_CALIBRATE : DAC_CONVERT;
    assign dac_code         = s_reg.sar;
    assign cal_bit          = s_reg.cal_idx;
    assign trim_code        = s_reg.trim;
    assign result           = s_reg.result;
    assign result_done      = s_reg.done;
    assign busy             = (s_reg.state != ST_TRACK);
    assign cal_busy         = (s_reg.state == ST_CAL);

    // ****************************************************************
    // checks
    // ****************************************************************
    a_msb_first: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == ST_WAIT_SYNC && conv_tick)
        |=> (s_reg.state == ST_CONVERT && s_reg.sar == MSB_ONLY))
        else $error("conversion did not start at half scale");
    a_clamp_high: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == ST_FINISH && master_tick && s_reg.clamp_hi)
        |=> (s_reg.done && s_reg.result == '1))
        else $error("over range not clamped to all ones");
    a_clamp_low: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == ST_FINISH && master_tick && s_reg.clamp_lo && !s_reg.clamp_hi)
        |=> (s_reg.done && s_reg.result == '0))
        else $error("under range not clamped to all zeros");
    a_hold_freeze: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == ST_TRACK && hold_fall && !cal_rise) |=> !track ##0 busy)
        else $error("hold edge did not freeze the sample");
    a_track_return: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == ST_FINISH && master_tick && s_reg.sync2[0]) |=> (track && result_done))
        else $error("no return to tracking after conversion");
    a_hold_repeat: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == ST_FINISH && master_tick && !s_reg.sync2[0])
        |=> (s_reg.state == ST_WAIT_SYNC && !track))
        else $error("hold held low did not restart conversion");
    a_conv_length: assert property (@(posedge clk) disable iff (!reset_n)
        s_reg.done |-> (s_reg.conv_cnt == 8'(CONV_TICKS)))
        else $error("conversion length in master periods is wrong");
    a_step_count: assert property (@(posedge clk) disable iff (!reset_n)
        s_reg.done |-> (s_reg.step_cnt == 5'(RES)))
        else $error("decision count differs from resolution");
    a_sync_delay: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == ST_WAIT_SYNC) |-> (s_reg.wait_cnt < 3'(`SAR_MASTER_DIV)))
        else $error("sequence start later than four master periods");
    a_result_hold: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(s_reg.result) |-> s_reg.done)
        else $error("result changed outside completion");
    a_trim_in_cal: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(s_reg.trim) |-> ($past(s_reg.state) == ST_CAL && $past(conv_tick)))
        else $error("trim changed outside calibration step");

endmodule
`default_nettype wire

/* hw/sar_pkg.sv */
// types shared by the conversion sequencer files
// assumes nothing of its surroundings
package sar_pkg;

    typedef enum logic [2:0] {
        ST_TRACK     = 3'h0,
        ST_WAIT_SYNC = 3'h1,
        ST_CONVERT   = 3'h2,
        ST_FINISH    = 3'h3,
        ST_CAL       = 3'h4
    } seq_state_t;

    typedef enum logic [1:0] {
        DAC_TRACK     = 2'h0,
        DAC_CONVERT   = 2'h1,
        DAC_CALIBRATE = 2'h2
    } dac_mode_t;

endpackage

/* verif/sar_conversion_sequencer_bench.sv */
// self-checking bench of the conversion sequencer with a queued result scoreboard
// assumes the design files under hw/ and the host model; 12-bit build, short idle count
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"

module sar_conversion_sequencer_bench
    import sar_pkg::*;
#(
    parameter int RES = 12
);
    // ****************************************************************
    // setup
    // ****************************************************************
    localparam int MP       = 4;
    localparam int IDLE     = 20;
    localparam int HOLD_LOW = 32;
    localparam int LIMIT    = 5000;
    localparam int LO       = (4 * RES + 1) * MP;
    localparam int HI       = (4 * RES + 6) * MP + 8;
    localparam int TW       = `SAR_TRIM_W;
    localparam int TRIM_EXP = `SAR_TRIM_RESET + `SAR_CAL_STEPS;

    logic                  clk;
    logic                  reset_n;
    logic                  bipolar;
    logic                  cal_start;
    logic                  over_range;
    logic                  under_range;
    logic                  master_clock_input;
    logic                  hold_n;
    logic                  cmp_below;
    logic                  track;
    logic                  msb_to_reference;
    dac_mode_t             dac_mode;
    logic [RES-1:0]        dac_code;
    logic [$clog2(RES)-1:0] cal_bit;
    logic [RES*TW-1:0]     trim_code;
    logic [RES-1:0]        result;
    logic                  result_done;
    logic                  busy;
    logic                  cal_busy;
    logic                  use_internal_osc;
    logic [RES-1:0]        exp_q[$];
    logic [RES-1:0]        last_result;
    logic [RES-1:0]        code;
    int                    n_errors;
    int                    tests_run;
    int                    n;

    sar_conversion_sequencer #(.RES(RES), .IDLE_CYCLES(IDLE)) i_sar_conversion_sequencer (
        .clk(clk), .reset_n(reset_n), .master_clock_input(master_clock_input),
        .hold_n(hold_n), .bipolar(bipolar), .cal_start(cal_start), .cmp_below(cmp_below),
        .over_range(over_range), .under_range(under_range), .track(track),
        .msb_to_reference(msb_to_reference), .dac_mode(dac_mode), .dac_code(dac_code),
        .cal_bit(cal_bit), .trim_code(trim_code), .result(result),
        .result_done(result_done), .busy(busy), .cal_busy(cal_busy),
        .use_internal_osc(use_internal_osc)
    );

    sar_host_model #(.RES(RES), .MCLK_HALF(MP / 2)) i_host (
        .clk(clk), .dac_code(dac_code), .master_clock_input(master_clock_input),
        .hold_n(hold_n), .cmp_below(cmp_below)
    );

    always #5 clk = ~clk;

    // ****************************************************************
    // checking
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        n_errors++;
        $display("[FAIL] %s expected event seen timeout", what);
        print_verdict();
    endtask

    // scoreboard: each done pulse takes the oldest note; result must not move in between
    always @(negedge clk) begin
        if (reset_n === 1'b1 && result_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[FAIL] result expected none seen %h", result);
            end else begin
                check("result", 32'(exp_q.pop_front()), 32'(result));
            end
        end else if (reset_n === 1'b1 && result !== last_result) begin
            check("result_steady", 32'(last_result), 32'(result));
        end
        last_result = result;
    end

    // ****************************************************************
    // stimulus
    // ****************************************************************
    task automatic wait_done(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
            if (cnt == 8) begin
                check("busy_in_conv", 1, 32'(busy));
                check("track_in_conv", 0, 32'(track));
                check("dac_mode_conv", 32'(DAC_CONVERT), 32'(dac_mode));
            end
            if (cnt > LIMIT) give_up("result_done");
        end while (result_done !== 1'b1);
    endtask

    task automatic run_conv(input logic [RES-1:0] c, input logic ovr, input logic und,
                            input logic [RES-1:0] exp, input int low, input bit twice,
                            input bit timed);
        int cnt;
        over_range = ovr;
        under_range = und;
        i_host.analog_input = c;
        exp_q.push_back(exp);
        if (twice) exp_q.push_back(exp);
        fork
            i_host.pulse_hold(low);
        join_none
        wait_done(cnt);
        if (timed) check("conv_clks", 1, 32'(cnt >= LO && cnt <= HI));
        check("busy_after_done", 32'(twice), 32'(busy));
        if (twice) wait_done(cnt);
        check("track_after_done", 1, 32'(track));
        repeat (40) @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        bipolar = 1'b0;
        cal_start = 1'b0;
        over_range = 1'b0;
        under_range = 1'b0;
        n_errors = 0;
        tests_run = 0;
        void'($urandom(48));
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        check("reset_result", 0, 32'(result));
        check("reset_busy", 0, 32'(busy));
        check("reset_track", 1, 32'(track));
        check("reset_dac_mode", 32'(DAC_TRACK), 32'(dac_mode));
        check("reset_trim", `SAR_TRIM_RESET, 32'(trim_code[TW-1:0]));
        repeat (10) @(negedge clk);
        // boundary codes first, then random ones
        for (int i = 0; i < 8; i++) begin
            code = (i == 0) ? '0 : (i == 1) ? '1 : RES'($urandom());
            run_conv(code, 1'b0, 1'b0, code, HOLD_LOW, 1'b0, 1'b1);
        end
        // clamps: high clamp wins when both flags are up
        for (int i = 1; i < 4; i++) begin
            run_conv(RES'($urandom()), i[0], i[1], i[0] ? '1 : '0, HOLD_LOW, 1'b0, 1'b1);
        end
        bipolar = 1'b1;
        repeat (6) @(negedge clk);
        check("msb_to_reference", 1, 32'(msb_to_reference));
        code = RES'($urandom());
        run_conv(code, 1'b0, 1'b0, code, HOLD_LOW, 1'b0, 1'b1);
        bipolar = 1'b0;
        repeat (6) @(negedge clk);
        check("msb_to_reference", 0, 32'(msb_to_reference));
        // hold left low past the end: a second conversion follows at once
        code = RES'($urandom());
        run_conv(code, 1'b0, 1'b0, code, LO + 60, 1'b1, 1'b0);
        // calibration with every weight reading low; a hold edge meanwhile is ignored
        i_host.force_below = 1'b1;
        repeat (4) @(negedge clk);
        cal_start = 1'b1;
        for (n = 0; cal_busy !== 1'b1; n++) begin
            @(negedge clk);
            if (n > 20) give_up("cal_busy");
        end
        cal_start = 1'b0;
        check("dac_mode", 32'(DAC_CALIBRATE), 32'(dac_mode));
        check("cal_bit_first", 0, 32'(cal_bit));
        fork
            i_host.pulse_hold(HOLD_LOW);
        join_none
        for (n = 0; cal_busy !== 1'b0; n++) begin
            @(negedge clk);
            if (n > LIMIT) give_up("cal_end");
        end
        i_host.force_below = 1'b0;
        for (int i = 0; i < RES; i++) begin
            check("trim", TRIM_EXP, 32'(trim_code[i*TW +: TW]));
        end
        repeat (40) @(negedge clk);
        // pin clock parked low: internal oscillator takes over, then hands back
        i_host.ext_run = 1'b0;
        for (n = 0; use_internal_osc !== 1'b1; n++) begin
            @(negedge clk);
            if (n > 200) give_up("internal_osc");
        end
        code = RES'($urandom());
        run_conv(code, 1'b0, 1'b0, code, HOLD_LOW, 1'b0, 1'b0);
        i_host.ext_run = 1'b1;
        for (n = 0; use_internal_osc !== 1'b0; n++) begin
            @(negedge clk);
            if (n > 200) give_up("external_osc");
        end
        check("use_internal_osc", 0, 32'(use_internal_osc));
        print_verdict();
    end
endmodule

`default_nettype wire

/* verif/sar_host_model.sv */
// host side stand-in: master clock pin, hold strobe and a comparator on the trial code
// assumes the bench drives everything at the falling edge of clk
`timescale 1ns/1ps
`default_nettype none

module sar_host_model #(
    parameter int RES      = 12,
    parameter int MCLK_HALF = 2
) (
    // clock
    input  wire logic           clk,
    // from the sequencer
    input  wire logic [RES-1:0] dac_code,
    // pins toward the sequencer
    output logic                master_clock_input,
    output logic                hold_n,
    output logic                cmp_below
);
    logic           ext_run;
    logic           force_below;
    logic [RES-1:0] analog_input;
    int             mdiv;

    initial begin
        master_clock_input = 1'b0;
        hold_n = 1'b1;
        cmp_below = 1'b0;
        ext_run = 1'b1;
        force_below = 1'b0;
        analog_input = '0;
        mdiv = 0;
    end

    // free-running pin clock; parked low to hand over to the internal oscillator
    always @(negedge clk) begin
        if (!ext_run) begin
            master_clock_input <= 1'b0;
            mdiv <= 0;
        end else if (mdiv == MCLK_HALF - 1) begin
            master_clock_input <= ~master_clock_input;
            mdiv <= 0;
        end else begin
            mdiv <= mdiv + 1;
        end
    end

    // ideal comparator; force_below makes every weight read low during trimming
    always @(negedge clk) begin
        cmp_below <= force_below | (analog_input < dac_code);
    end

    // low time covers one master period plus margin; with HOLD_LOW the release comes before the end, with LO + 60 after it
    task automatic pulse_hold(input int low_clk);
        @(negedge clk);
        hold_n <= 1'b0;
        repeat (low_clk) @(negedge clk);
        hold_n <= 1'b1;
    endtask
endmodule

`default_nettype wire
